// *** inc/adcc_pkg.sv ***
// Package: register map, field positions, reset values and timing for the converter control
`default_nettype none
package adcc_pkg;
    // ************************************************************
    // Register map (word index times four gives the APB byte address)
    // ************************************************************
    localparam logic [11:0] ADCC_STATUS_CONTROL_INDEX = 12'h038;
    localparam logic [11:0] ADCC_DATA_INDEX = 12'h039;
    localparam logic [11:0] ADCC_STATUS_CONTROL_OFFSET = ADCC_STATUS_CONTROL_INDEX * 12'h004;
    localparam logic [11:0] ADCC_DATA_OFFSET = ADCC_DATA_INDEX * 12'h004;
    localparam logic [11:0] ADCC_CLOCK_OFFSET = 12'h040;
    localparam logic [11:0] ADCC_PORT_OFFSET = 12'h044;
    // ************************************************************
    // Status/control fields
    // ************************************************************
    localparam int ADCC_DONE_BIT = 7;
    localparam int ADCC_IRQ_EN_BIT = 6;
    localparam int ADCC_CONT_BIT = 5;
    localparam logic [7:0] ADCC_SCR_RESET = 8'h1f;
    localparam logic [4:0] ADCC_CH_LAST_EXT = 5'h0e;
    localparam logic [4:0] ADCC_CH_OFF = 5'h1f;
    localparam logic [4:0] ADCC_CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] ADCC_CH_REF_SUPPLY = 5'h1c;
    localparam logic [4:0] ADCC_CH_REF_LOW = 5'h1e;
    // ************************************************************
    // Clock register fields
    // ************************************************************
    localparam int ADCC_SRC_BIT = 4;
    localparam logic [7:0] ADCC_CLK_RESET = 8'h00;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam logic [4:0] ADCC_CONV_CYCLES = 5'h10;
    localparam int ADCC_NUM_CH = 15;
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONVERT = 2'b10
    } adcc_state_type;
endpackage : adcc_pkg
`default_nettype wire

// *** inc/adcc_tick_if.sv ***
// Interface: divided converter clock tick from the prescaler to the control core
`default_nettype none
interface adcc_tick_if;
    logic [2:0] divider;
    logic src_bus;
    logic tick;
    modport ctrl (output divider, output src_bus, input tick);
    modport pre (input divider, input src_bus, output tick);
endinterface : adcc_tick_if
`default_nettype wire

// *** hdl/adcc_prescaler.sv ***
// Prescaler: makes one converter clock tick per 1, 2, 4, 8 or 16 source edges
`default_nettype none
module adcc_prescaler
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Oscillator clock enable, already synchronised
    input wire logic osc_tick_in,
    // Tick link
    adcc_tick_if.pre tk
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } adcc_pre_type;
    adcc_pre_type st_ff, nxt_st;
    logic src_edge;
    logic [3:0] limit;
    always_comb begin
        nxt_st = st_ff;
        src_edge = tk.src_bus ? 1'b1 : osc_tick_in;
        unique case (tk.divider[2] ? 3'b100 : tk.divider)
            3'b000: limit = 4'h0;
            3'b001: limit = 4'h1;
            3'b010: limit = 4'h3;
            3'b011: limit = 4'h7;
            default: limit = 4'hf;
        endcase
        nxt_st.tick = 1'b0;
        if (src_edge) begin
            if (st_ff.cnt >= limit) begin
                nxt_st.cnt = 4'h0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign tk.tick = st_ff.tick;
endmodule : adcc_prescaler
`default_nettype wire

// *** hdl/adcc_top.sv ***
// Converter control top: APB registers, pin steering, conversion sequencing
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Clock sources and power modes
    input wire logic osc_clk_in,
    input wire logic stop_mode_in,
    input wire logic wait_mode_in,
    // Comparator and analog mux
    input wire logic comparator_in,
    output logic [4:0] mux_select_out,
    output logic [7:0] dac_code_out,
    output logic sample_out,
    output logic analog_power_out,
    // Shared port pins
    input wire logic [14:0] port_pin_in,
    output logic [14:0] port_pin_out,
    output logic [14:0] port_pin_oe_out,
    output logic [14:0] analog_pin_out,
    // Service requests
    output logic cpu_irq_out,
    output logic dma_req_out,
    output logic wake_out
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] scr;
        logic [7:0] clk_reg;
        logic [7:0] result;
        logic [7:0] sar;
        logic [7:0] bitmask;
        logic [4:0] tcnt;
        adcc_state_type fsm;
        logic pending;
        logic [14:0] latch;
        logic [14:0] ddr;
        logic [2:0] osc_sync;
        logic [2:0] cmp_sync;
        logic osc_prev;
        logic osc_tick;
        logic [31:0] rdata;
        logic [44:0] pin_sync;
        logic [14:0] pin_val;
        logic cmp_val;
    } adcc_top_type;
    adcc_top_type st_ff, nxt_st;
    adcc_tick_if tk_if ();
    adcc_prescaler u_pre (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .osc_tick_in(st_ff.osc_tick),
        .tk(tk_if.pre)
    );
    assign tk_if.divider = st_ff.clk_reg[2:0];
    assign tk_if.src_bus = st_ff.clk_reg[ADCC_SRC_BIT];
    logic acc;
    logic wr_scr;
    logic rd_data;
    logic powered;
    logic start;
    logic [14:0] sel_onehot;
    logic [14:0] pin_now;
    logic cmp_now;
    logic [7:0] trial;
    always_comb begin
        nxt_st = st_ff;
        acc = psel_in && penable_in;
        wr_scr = acc && pwrite_in && (paddr_in == ADCC_STATUS_CONTROL_OFFSET);
        rd_data = acc && !pwrite_in && (paddr_in == ADCC_DATA_OFFSET);
        powered = (st_ff.scr[4:0] != ADCC_CH_OFF) && !stop_mode_in;
        for (int i = 0; i < ADCC_NUM_CH; i++) begin
            sel_onehot[i] = (st_ff.scr[4:0] == 5'(i));
            // Third stage counts once it agrees with the second
            pin_now[i] = (st_ff.pin_sync[3*i+2] == st_ff.pin_sync[3*i+1])
                ? st_ff.pin_sync[3*i+2] : st_ff.pin_val[i];
        end
        // Sampling delay needs at least four core clocks per converter tick
        cmp_now = (st_ff.cmp_sync[2] == st_ff.cmp_sync[1]) ? st_ff.cmp_sync[2] : st_ff.cmp_val;
        nxt_st.pin_val = pin_now;
        nxt_st.cmp_val = cmp_now;
        // Three-stage sampling of asynchronous inputs
        nxt_st.osc_sync = {st_ff.osc_sync[1:0], osc_clk_in};
        nxt_st.cmp_sync = {st_ff.cmp_sync[1:0], comparator_in};
        for (int i = 0; i < ADCC_NUM_CH; i++) begin
            nxt_st.pin_sync[3*i +: 3] = {st_ff.pin_sync[3*i +: 2], port_pin_in[i]};
        end
        if (st_ff.osc_sync[2] == st_ff.osc_sync[1]) begin
            nxt_st.osc_prev = st_ff.osc_sync[2];
        end
        nxt_st.osc_tick = (st_ff.osc_sync[2] == st_ff.osc_sync[1])
            && st_ff.osc_sync[2] && !st_ff.osc_prev;
        // ************************************************************
        // Register writes
        // ************************************************************
        start = 1'b0;
        if (acc && pwrite_in) begin
            unique case (paddr_in)
                ADCC_STATUS_CONTROL_OFFSET: begin
                    nxt_st.scr[6:0] = pwdata_in[6:0];
                    nxt_st.scr[ADCC_DONE_BIT] = pwdata_in[ADCC_IRQ_EN_BIT]
                        & pwdata_in[ADCC_DONE_BIT];
                    start = 1'b1;
                end
                ADCC_CLOCK_OFFSET: nxt_st.clk_reg = {3'h0, pwdata_in[4:0]};
                ADCC_PORT_OFFSET: begin
                    // Selected pin keeps its latch and direction untouched
                    for (int i = 0; i < ADCC_NUM_CH; i++) begin
                        if (!sel_onehot[i]) begin
                            nxt_st.latch[i] = pwdata_in[i];
                            nxt_st.ddr[i] = pwdata_in[16+i];
                        end
                    end
                end
                default: ;
            endcase
        end
        if (wr_scr || rd_data) begin
            nxt_st.pending = 1'b0;
            if (!st_ff.scr[ADCC_IRQ_EN_BIT] && rd_data) begin
                nxt_st.scr[ADCC_DONE_BIT] = 1'b0;
            end
        end
        // ************************************************************
        // Conversion sequencer
        // ************************************************************
        trial = st_ff.sar | st_ff.bitmask;
        if (start) begin
            nxt_st.fsm = ADCC_SAMPLE;
            nxt_st.tcnt = 5'h0;
            nxt_st.sar = 8'h00;
            nxt_st.bitmask = 8'h80;
        end else if (!powered) begin
            nxt_st.fsm = (st_ff.fsm != ADCC_IDLE && stop_mode_in) ? ADCC_SAMPLE
                : (powered ? st_ff.fsm : (stop_mode_in ? st_ff.fsm : ADCC_IDLE));
            if (stop_mode_in && st_ff.fsm != ADCC_IDLE) begin
                nxt_st.tcnt = 5'h0;
                nxt_st.sar = 8'h00;
                nxt_st.bitmask = 8'h80;
            end
        end else if (tk_if.tick) begin
            nxt_st.tcnt = st_ff.tcnt + 5'h1;
            unique case (st_ff.fsm)
                ADCC_IDLE: ;
                ADCC_SAMPLE: begin
                    if (st_ff.tcnt == ADCC_CONV_CYCLES - 5'h8) begin
                        nxt_st.fsm = ADCC_CONVERT;
                    end
                end
                ADCC_CONVERT: begin
                    // One bit per tick, compared against the trial code
                    if (st_ff.bitmask != 8'h00) begin
                        nxt_st.sar = cmp_now ? trial : st_ff.sar;
                        nxt_st.bitmask = st_ff.bitmask >> 1;
                    end
                    // Seventeenth tick: the first tick after a start is a partial period
                    if (st_ff.tcnt == ADCC_CONV_CYCLES) begin
                        nxt_st.result = nxt_st.sar;
                        nxt_st.pending = 1'b1;
                        if (!st_ff.scr[ADCC_IRQ_EN_BIT]) begin
                            nxt_st.scr[ADCC_DONE_BIT] = 1'b1;
                        end
                        if (st_ff.scr[ADCC_CONT_BIT]) begin
                            nxt_st.fsm = ADCC_SAMPLE;
                            nxt_st.tcnt = 5'h0;
                            nxt_st.sar = 8'h00;
                            nxt_st.bitmask = 8'h80;
                        end else begin
                            nxt_st.fsm = ADCC_IDLE;
                        end
                    end
                end
                default: nxt_st.fsm = ADCC_IDLE;
            endcase
        end
        // ************************************************************
        // Read data
        // ************************************************************
        nxt_st.rdata = 32'h0;
        if (psel_in && !penable_in && !pwrite_in) begin
            unique case (paddr_in)
                ADCC_STATUS_CONTROL_OFFSET: nxt_st.rdata = {24'h0, st_ff.scr};
                ADCC_DATA_OFFSET: nxt_st.rdata = {24'h0, st_ff.result};
                ADCC_CLOCK_OFFSET: nxt_st.rdata = {24'h0, st_ff.clk_reg};
                ADCC_PORT_OFFSET: begin
                    for (int i = 0; i < ADCC_NUM_CH; i++) begin
                        if (sel_onehot[i]) begin
                            nxt_st.rdata[i] = st_ff.ddr[i] & st_ff.latch[i];
                        end else begin
                            nxt_st.rdata[i] = st_ff.ddr[i] ? st_ff.latch[i] : pin_now[i];
                        end
                    end
                    nxt_st.rdata[30:16] = st_ff.ddr;
                end
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_ff <= '0;
            st_ff.scr <= ADCC_SCR_RESET;
            st_ff.clk_reg <= ADCC_CLK_RESET;
            st_ff.bitmask <= 8'h80;
            st_ff.fsm <= ADCC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in
        && (paddr_in != ADCC_STATUS_CONTROL_OFFSET) && (paddr_in != ADCC_DATA_OFFSET)
        && (paddr_in != ADCC_CLOCK_OFFSET) && (paddr_in != ADCC_PORT_OFFSET);
    assign prdata_out = st_ff.rdata;
    assign mux_select_out = st_ff.scr[4:0];
    assign dac_code_out = st_ff.sar | st_ff.bitmask;
    assign sample_out = (st_ff.fsm == ADCC_SAMPLE);
    assign analog_power_out = powered;
    assign analog_pin_out = sel_onehot;
    assign port_pin_out = st_ff.latch;
    assign port_pin_oe_out = st_ff.ddr & ~sel_onehot;
    assign cpu_irq_out = st_ff.scr[ADCC_IRQ_EN_BIT] && st_ff.pending
        && !st_ff.scr[ADCC_DONE_BIT];
    assign dma_req_out = st_ff.scr[ADCC_IRQ_EN_BIT] && st_ff.pending
        && st_ff.scr[ADCC_DONE_BIT];
    assign wake_out = cpu_irq_out && wait_mode_in;
endmodule : adcc_top
`default_nettype wire

// *** sim/adcc_top_sva.sv ***
// Checker: pin steering, request and conversion timing relations at the top ports
`default_nettype none
module adcc_top_sva
    import adcc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic stop_mode_in,
    input wire logic wait_mode_in,
    input wire logic [4:0] mux_select_out,
    input wire logic [7:0] dac_code_out,
    input wire logic analog_power_out,
    input wire logic [14:0] port_pin_oe_out,
    input wire logic [14:0] analog_pin_out,
    input wire logic cpu_irq_out,
    input wire logic dma_req_out,
    input wire logic wake_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ************************************************************
    // Sequences and properties
    // ************************************************************
    sequence s_scr_wr;
        psel_in && penable_in && pwrite_in && paddr_in == ADCC_STATUS_CONTROL_OFFSET;
    endsequence
    sequence s_quiet;
        (!cpu_irq_out && !dma_req_out) [*8] ##1 (!cpu_irq_out && !dma_req_out) [*6];
    endsequence
    property p_quiet; s_scr_wr |=> s_quiet; endproperty
    property p_mux; s_scr_wr |=> mux_select_out == $past(pwdata_in[4:0]); endproperty
    property p_onehot;
        analog_pin_out == ((mux_select_out <= ADCC_CH_LAST_EXT) ? 15'h1 << mux_select_out : 15'h0);
    endproperty
    property p_oe; (port_pin_oe_out & analog_pin_out) == 15'h0; endproperty
    property p_off;
        mux_select_out == ADCC_CH_OFF && $past(mux_select_out) == ADCC_CH_OFF |-> !analog_power_out;
    endproperty
    property p_stop; stop_mode_in && $past(stop_mode_in) |-> !analog_power_out; endproperty
    property p_steer; !(cpu_irq_out && dma_req_out); endproperty
    property p_wake; wake_out == (cpu_irq_out && wait_mode_in); endproperty
    property p_rst;
        $fell(rst_in) |-> mux_select_out == ADCC_CH_OFF && dac_code_out == 8'h80 && !cpu_irq_out;
    endproperty
    // ************************************************************
    // Assertions
    // ************************************************************
    a_quiet: assert property (p_quiet) else $error("request too soon after status write");
    a_mux: assert property (p_mux) else $error("channel not taken from write");
    a_onehot: assert property (p_onehot) else $error("analog pin steering wrong");
    a_oe: assert property (p_oe) else $error("selected pin still driven");
    a_off: assert property (p_off) else $error("converter powered with channel off");
    a_stop: assert property (p_stop) else $error("converter powered in stop");
    a_steer: assert property (p_steer) else $error("both requests high");
    a_wake: assert property (p_wake) else $error("wake not following request");
    a_rst: assert property (p_rst) else $error("wrong values after reset");
endmodule // adcc_top_sva
bind adcc_top adcc_top_sva u_sva (.core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .stop_mode_in, .wait_mode_in, .mux_select_out, .dac_code_out,
    .analog_power_out, .port_pin_oe_out, .analog_pin_out, .cpu_irq_out, .dma_req_out,
    .wake_out);
`default_nettype wire

// *** sim/adcc_top_tb_top.sv ***
// Testbench: APB register tests, conversions, steering and power modes
`default_nettype none
module adcc_top_tb_top
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, osc = 0, stop = 0, wt = 0;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prd;
    logic [14:0] pin = '0, pout, poe, apin, ddr, lat, dm;
    logic [7:0] vin = '0, dac, old;
    logic [1:0] oc = '0;
    logic prdy, perr, smp, pon, irq, dma, wake;
    logic [4:0] mux;
    int n_errors = 0, cmp_count = 0, n, r;
    logic [32:0] q[$];
    wire cmp = vin >= dac;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        oc <= oc + 2'h1;
        osc <= oc[1];
    end
    adcc_top DUT (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .osc_clk_in(osc), .stop_mode_in(stop), .wait_mode_in(wt),
        .comparator_in(cmp), .mux_select_out(mux), .dac_code_out(dac), .sample_out(smp),
        .analog_power_out(pon), .port_pin_in(pin), .port_pin_out(pout),
        .port_pin_oe_out(poe), .analog_pin_out(apin), .cpu_irq_out(irq),
        .dma_req_out(dma), .wake_out(wake));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ************************************************************
    // APB master; expectation noted at setup, compared by monitor
    // ************************************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        q.push_back(e);
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (!prdy);
        psel <= 0; pen <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d, '0); endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, '0, {1'b0, e}); endtask
    task automatic wreq;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(irq || dma) && n < 2000);
    endtask
    task automatic wconv; repeat (160) @(posedge clk); endtask
    always @(posedge clk) if (psel && pen && prdy) check({perr, pwr ? 32'h0 : prd}, q.pop_front());
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(87));
        repeat (8) @(posedge clk);
        rst <= 0;
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'h1f);
        rd(ADCC_CLOCK_OFFSET, 32'h0);
        apb(0, 12'h050, '0, {1'b1, 32'h0});
        check(pon, 1'b0);
        for (int k = 0; k < 8; k++) begin
            r = k > 3 ? 16 : 1 << k;
            wr(ADCC_CLOCK_OFFSET, 32'h10 | k);
            vin <= k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
            wt <= k[0];
            wr(ADCC_STATUS_CONTROL_OFFSET, 32'h40 | (k + 7));
            wreq;
            check(n >= 16 * r && n <= 17 * r + 3, 1'b1);
            check({irq, dma, wake, apin}, {2'b10, k[0], 15'h1 << (k + 7)});
            rd(ADCC_DATA_OFFSET, {24'h0, vin});
            @(negedge clk);
            check(irq, 1'b0);
        end
        wr(ADCC_CLOCK_OFFSET, 32'h12);
        wt <= 0;
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h42);
        repeat (5) @(negedge clk);
        check({smp, dac}, {1'b1, 8'h80});
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h49);
        wreq;
        check({n >= 64 && n <= 72, mux}, {1'b1, 5'h09});
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'hc3);
        wreq;
        check({dma, irq}, 2'b10);
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'hc3);
        rd(ADCC_DATA_OFFSET, {24'h0, vin});
        @(negedge clk);
        check(dma, 1'b0);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h05);
        wconv;
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'h85);
        rd(ADCC_DATA_OFFSET, {24'h0, vin});
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'h05);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h85);
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'h05);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h25);
        wconv;
        vin <= 8'($urandom);
        wconv;
        rd(ADCC_STATUS_CONTROL_OFFSET, 32'ha5);
        rd(ADCC_DATA_OFFSET, {24'h0, vin});
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h05);
        wconv;
        old = vin;
        vin <= ~vin;
        wconv;
        rd(ADCC_DATA_OFFSET, {24'h0, old});
        ddr = 15'($urandom) | 15'h8;
        lat = 15'($urandom) | 15'h8;
        dm = ddr & ~15'h8;
        pin <= 15'($urandom);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h03);
        wr(ADCC_PORT_OFFSET, {1'b0, ddr, 1'b0, lat});
        repeat (4) @(negedge clk);
        check({poe, pout}, {dm, lat & ~15'h8});
        rd(ADCC_PORT_OFFSET, {1'b0, dm, 1'b0, (dm & lat) | (~ddr & pin & ~15'h8)});
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h43);
        repeat (5) @(posedge clk);
        stop <= 1;
        repeat (40) @(negedge clk);
        check({irq, pon}, 2'b00);
        @(posedge clk);
        stop <= 0;
        wreq;
        check(n >= 64 && n <= 72, 1'b1);
        rd(ADCC_DATA_OFFSET, {24'h0, vin});
        wr(ADCC_CLOCK_OFFSET, 32'h0);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h45);
        wreq;
        check(n >= 64 && n <= 80, 1'b1);
        wr(ADCC_STATUS_CONTROL_OFFSET, 32'h1f);
        repeat (3) @(negedge clk);
        check(pon, 1'b0);
        end_of_test;
    end
endmodule // adcc_top_tb_top
`default_nettype wire
